/* File: design/xps_ctrl.sv */
// serial slave and double-buffered switch store of the 8x8 crosspoint array
`timescale 1ns/1ns
`default_nettype none

// How it works
// (R01) reset pin low opens all 64 switches
// (R02) power-up reset zeroes switches and registers
// (R03) load bit set applies state after word
// (R04) load bit clear holds; last word applies all
// (R05) readback in standard and fast modes only
// (R06) slave only; serial clock never driven
// (R07) runs at standard, fast, high-speed rates
// (R08) address is 1110 plus three strap pins
// (R09) start, then eight bits: address, direction
// (R10) matching address acked on ninth pulse
// (R11) direction 1 reads, 0 writes
// (R12) nine pulses per byte, receiver acks
// (R13) data changes only while clock low
// (R14) master ends with stop after write
// (R15) master nacks, then stops, after read
// (R16) write is address byte plus two bytes
// (R17) top command bit closes or opens switch
// (R18) row and column codes from command bits
// (R19) ignore middle bits; bit 0 is load bit
// (R20) any combination of closed switches allowed
// (R21) a write changes only its own switch
// (R22) master keeps reset pin high when writing
// (R23) row codes map, some codes reserved
// (R24) reserved row code changes nothing
// (R25) reset clears pending and applied stages
module xps_ctrl
  import xps_pkg::*;
(
  input  wire logic        core_clk_i,       // block clock, 125 MHz
  input  wire logic        rst_i,            // power-on reset, active high, synchronous
  input  wire logic        reset_n_i,        // reset pin, active low, asynchronous source
  input  wire logic        scl_i,            // serial clock pin level
  input  wire logic        sda_i,            // serial data pin level
  output logic             sda_o,            // serial data output value, always low
  output logic             sda_oe_n_o,       // low while pulling the data line low
  input  wire logic        addr_strap_bit0_i, // address bit 0 strap
  input  wire logic        addr_strap_bit1_i, // address bit 1 strap
  input  wire logic        addr_strap_bit2_i, // address bit 2 strap
  output logic [63:0]      switch_state_o,   // applied switches, bit row*8+column
  output logic [63:0]      pending_state_o,  // latched switches awaiting the load bit
  output logic             hs_mode_o         // high-speed mode entered until stop
);

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  xps_pins_t pins_s1_q, pins_s2_q, pins_s3_q; // three-stage chain
  xps_pins_t filt_q, filt_d;                  // agreed pin levels
  xps_pins_t pins_raw;                        // pins gathered as one word
  xps_pins_t agree;                           // stages two and three agree

  assign pins_raw = '{scl: scl_i, sda: sda_i, reset_n: reset_n_i,
                      strap: {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i}};

  // a level only counts once stages two and three agree; this also swallows
  // single-sample glitches on the open-drain lines
  always_comb begin
    agree  = ~(pins_s2_q ^ pins_s3_q);
    filt_d = (filt_q & ~agree) | (pins_s3_q & agree);
  end

  // stage one feeds stage two only
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pins_s1_q <= PINS_IDLE;
      pins_s2_q <= PINS_IDLE;
      pins_s3_q <= PINS_IDLE;
      filt_q    <= PINS_IDLE;
    end else begin
      pins_s1_q <= pins_raw;
      pins_s2_q <= pins_s1_q;
      pins_s3_q <= pins_s2_q;
      filt_q    <= filt_d;
    end
  end

  // ***************************************************************
  // bus events
  // ***************************************************************
  logic scl_rise;     // serial clock rising
  logic scl_fall;     // serial clock falling
  logic bus_start;    // data falls while clock high
  logic bus_stop;     // data rises while clock high
  logic clr;          // reset pin or power-on reset
  logic [6:0] own_addr; // our slave address

  // the serial clock is only ever sampled, never driven
  always_comb begin
    scl_rise  = ~filt_q.scl & filt_d.scl;                                // R06
    scl_fall  = filt_q.scl & ~filt_d.scl;
    bus_start = filt_q.scl & filt_d.scl & filt_q.sda & ~filt_d.sda;     // R09
    bus_stop  = filt_q.scl & filt_d.scl & ~filt_q.sda & filt_d.sda;     // R13
    clr       = rst_i | ~filt_q.reset_n;                                 // R01 R02
    own_addr  = {ADDR_FIXED, filt_q.strap};                              // R08
  end

  // ***************************************************************
  // serial engine and switch store
  // ***************************************************************
  xps_state_t    state_q, state_d;     // engine state
  logic [3:0]    cnt_q, cnt_d;         // bits seen in this byte
  logic [7:0]    shreg_q, shreg_d;     // receive shift register
  logic [7:0]    tx_q, tx_d;           // readback byte being sent
  logic          half_q, half_d;       // 1 once the first command byte is in
  logic          mack_q, mack_d;       // master acked the last read byte
  logic          hs_q, hs_d;           // high-speed mode in force
  logic          oe_n_q, oe_n_d;       // data line release, low pulls low
  xps_cmd_word_t cmd_q, cmd_d;         // switch_command_word
  logic [63:0]   pend_q, pend_d;       // pending latch stage
  logic [63:0]   appl_q, appl_d;       // applied switch stage
  logic [2:0]    rd_row_q, rd_row_d;   // row shown on readback
  xps_row_t      row_dec;              // decoded row of a complete word
  xps_cmd_word_t word_in;              // word with its final byte merged

  // next-state logic; start and stop take precedence over bit handling
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    shreg_d  = shreg_q;
    tx_d     = tx_q;
    half_d   = half_q;
    mack_d   = mack_q;
    hs_d     = hs_q;
    oe_n_d   = oe_n_q;
    cmd_d    = cmd_q;
    pend_d   = pend_q;
    appl_d   = appl_q;
    rd_row_d = rd_row_q;
    word_in  = cmd_q;
    word_in.unused          = shreg_q[7:1];                              // R19
    word_in.load_update_bit = shreg_q[0];                                // R19
    row_dec  = row_decode(word_in.row_select_code);                      // R23

    if (bus_stop) begin
      // a stop frees the bus and drops high-speed mode
      state_d = ST_IDLE;                                                 // R14 R15
      hs_d    = 1'b0;
      oe_n_d  = 1'b1;
    end else if (bus_start) begin
      // start or repeated start; high-speed mode survives a repeated start
      state_d = ST_ADDR;                                                 // R09
      cnt_d   = CNT_RESET;
      oe_n_d  = 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_SKIP: begin
          // not ours: stay off the bus until the next start
          oe_n_d = 1'b1;                                                 // R10
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            // sample msb first while the clock is high
            shreg_d = {shreg_q[6:0], filt_d.sda};                        // R09
            cnt_d   = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            cnt_d = CNT_RESET;
            if (state_q == ST_ADDR) begin
              if (shreg_q[7:1] == own_addr &&
                  !(shreg_q[0] == DIR_READ && hs_q)) begin
                // our address: pull low for the ninth pulse
                state_d         = ST_ADDR_ACK;                           // R10 R05
                oe_n_d          = 1'b0;                                  // R12
                cmd_d.dev_addr  = shreg_q[7:1];
                cmd_d.rd_not_wr = shreg_q[0];                            // R11
              end else if (shreg_q[7:3] == HS_MASTER_CODE) begin
                // master code is never acked; it enters high-speed mode, where read addresses are not acked
                hs_d    = 1'b1;                                          // R07
                state_d = ST_SKIP;
              end else begin
                state_d = ST_SKIP;                                       // R10
              end
            end else begin
              state_d = ST_WR_ACK;
              oe_n_d  = 1'b0;                                            // R12
              half_d  = ~half_q;
              if (!half_q) begin
                // first command byte: switch value, row and column codes
                cmd_d.switch_on          = shreg_q[7];                   // R16 R17
                cmd_d.row_select_code    = shreg_q[6:3];                 // R18
                cmd_d.column_select_code = shreg_q[2:0];                 // R18
              end else begin
                cmd_d = word_in;                                         // R16
                if (row_dec.valid) begin                                 // R24
                  // touch only the addressed bit of the latch
                  pend_d[sw_index(row_dec.idx, word_in.column_select_code)] =
                    word_in.switch_on;                                   // R20 R21
                  rd_row_d = row_dec.idx;
                end
                // reserved rows leave latch and switches untouched
                if (word_in.load_update_bit && row_dec.valid) begin      // R24
                  appl_d = pend_d;                                       // R03 R04
                end
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_d = CNT_RESET;
            if (cmd_q.rd_not_wr == DIR_READ) begin
              // put the first readback bit out as the ack ends
              state_d = ST_RD;                                           // R11 R05
              tx_d    = appl_q[sw_index(rd_row_q, 3'h0) +: 8];
              oe_n_d  = appl_q[sw_index(rd_row_q, 3'h7)];                // R13
            end else begin
              state_d = ST_WR;
              half_d  = 1'b0;
              oe_n_d  = 1'b1;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            // release after the ninth pulse; further pairs form new words
            state_d = ST_WR;
            oe_n_d  = 1'b1;                                              // R12
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == BITS_PER_BYTE) begin
              // hand the line to the master for its ack
              state_d = ST_RD_ACK;
              oe_n_d  = 1'b1;                                            // R12
            end else begin
              oe_n_d  = tx_q[3'(4'h7 - cnt_q)];                          // R13
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            mack_d = ~filt_d.sda;
          end else if (scl_fall) begin
            cnt_d = CNT_RESET;
            if (mack_q) begin
              // master acked: send the same row again
              state_d = ST_RD;
              tx_d    = appl_q[sw_index(rd_row_q, 3'h0) +: 8];
              oe_n_d  = appl_q[sw_index(rd_row_q, 3'h7)];
            end else begin
              state_d = ST_SKIP;                                         // R15
            end
          end
        end
        default: begin
          // an illegal code recovers to idle with the line released
          state_d = ST_IDLE;
          oe_n_d  = 1'b1;
        end
      endcase
    end
  end

  // registers; the reset pin clears both store stages, not just the switches
  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      state_q  <= ST_IDLE;
      cnt_q    <= CNT_RESET;
      shreg_q  <= 8'h00;
      tx_q     <= 8'h00;
      half_q   <= 1'b0;
      mack_q   <= 1'b0;
      hs_q     <= 1'b0;
      oe_n_q   <= 1'b1;
      cmd_q    <= CMD_RESET;                                             // R02
      pend_q   <= SW_RESET;                                              // R25
      appl_q   <= SW_RESET;                                              // R01 R25
      rd_row_q <= ROW_RESET;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      shreg_q  <= shreg_d;
      tx_q     <= tx_d;
      half_q   <= half_d;
      mack_q   <= mack_d;
      hs_q     <= hs_d;
      oe_n_q   <= oe_n_d;
      cmd_q    <= cmd_d;
      pend_q   <= pend_d;
      appl_q   <= appl_d;
      rd_row_q <= rd_row_d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // open-drain: the value is always low, only the enable moves. at 3.4 MHz
  // the four-cycle sampling delay still fits well inside the clock low time
  assign sda_o           = 1'b0;
  assign sda_oe_n_o      = oe_n_q;
  assign switch_state_o  = appl_q;
  assign pending_state_o = pend_q;
  assign hs_mode_o       = hs_q;

endmodule
`default_nettype wire

/* File: design/xps_pkg.sv */
// constants, carriers and decode helpers for the crosspoint switch serial control block
package xps_pkg;

  // ***************************************************************
  // array geometry and reset values
  // ***************************************************************
  localparam int unsigned NUM_SW        = 64;      // 8 row lines by 8 column lines
  localparam logic [63:0] SW_RESET      = 64'h0;   // every switch open
  localparam logic [23:0] CMD_RESET     = 24'h0;   // command word cleared
  localparam logic [2:0]  ROW_RESET     = 3'h0;    // readback row after reset

  // ***************************************************************
  // serial bus constants
  // ***************************************************************
  localparam logic [3:0] ADDR_FIXED     = 4'he;    // upper four address bits, 1110
  localparam logic [4:0] HS_MASTER_CODE = 5'h01;   // 00001xxx enters high-speed mode
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;    // data bits before the ack slot
  localparam logic [3:0] CNT_RESET      = 4'h0;    // bit counter start
  localparam logic       DIR_READ       = 1'b1;    // direction bit value for a read

  // ***************************************************************
  // row select decode
  // ***************************************************************
  localparam logic [3:0] ROW_CODE_LAST_DIRECT = 4'h5; // 0000..0101 give rows 0..5
  localparam logic [3:0] ROW_CODE_ROW6        = 4'h8; // 1000 gives row 6
  localparam logic [3:0] ROW_CODE_ROW7        = 4'h9; // 1001 gives row 7
  localparam logic [2:0] ROW_IDX_ROW6         = 3'h6;
  localparam logic [2:0] ROW_IDX_ROW7         = 3'h7;

  // ***************************************************************
  // carriers
  // ***************************************************************
  // the 24-bit command word as shifted in, first bit at the top
  typedef struct packed {
    logic [6:0] dev_addr;            // slave address
    logic       rd_not_wr;           // direction bit
    logic       switch_on;           // 1 closes, 0 opens
    logic [3:0] row_select_code;     // row line code
    logic [2:0] column_select_code;  // column line code
    logic [6:0] unused;              // ignored bits
    logic       load_update_bit;     // 1 applies pending state
  } xps_cmd_word_t;

  // pins from outside the clock domain, synchronised together
  typedef struct packed {
    logic       scl;                 // serial clock from the master
    logic       sda;                 // serial data line level
    logic       reset_n;             // reset pin, active low
    logic [2:0] strap;               // address strap pins
  } xps_pins_t;

  localparam xps_pins_t PINS_IDLE = 6'h38; // bus released, reset pin high, straps low

  // decoded row selection
  typedef struct packed {
    logic       valid;               // code is not reserved
    logic [2:0] idx;                 // row line index
  } xps_row_t;

  // one-hot serial engine states
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,             // waiting for a start
    ST_ADDR     = 8'h02,             // shifting the address byte
    ST_ADDR_ACK = 8'h04,             // acknowledging our address
    ST_WR       = 8'h08,             // shifting a command byte
    ST_WR_ACK   = 8'h10,             // acknowledging a command byte
    ST_RD       = 8'h20,             // sending readback bits
    ST_RD_ACK   = 8'h40,             // sampling the master's ack
    ST_SKIP     = 8'h80              // not addressed, wait for start or stop
  } xps_state_t;

  // row code to row index; reserved codes come back invalid
  function automatic xps_row_t row_decode(input logic [3:0] code);
    xps_row_t r;
    r.valid = 1'b1;
    r.idx   = code[2:0];
    if (code == ROW_CODE_ROW6) begin
      r.idx = ROW_IDX_ROW6;
    end else if (code == ROW_CODE_ROW7) begin
      r.idx = ROW_IDX_ROW7;
    end else if (code > ROW_CODE_LAST_DIRECT) begin
      r.valid = 1'b0;
    end
    return r;
  endfunction

  // flat switch index: row times eight plus column
  function automatic logic [5:0] sw_index(input logic [2:0] row, input logic [2:0] col);
    return {row, col};
  endfunction

endpackage

/* File: tb/xps_ctrl_sva.sv */
// assertion checker for the crosspoint switch serial control block
`timescale 1ns/1ns
`default_nettype none
module xps_ctrl_sva (
  input wire logic        core_clk_i,      // block clock
  input wire logic        rst_i,           // power-on reset, high
  input wire logic        reset_n_i,       // reset pin, low
  input wire logic        scl_i,           // serial clock level
  input wire logic        sda_o,           // open drain value
  input wire logic        sda_oe_n_o,      // low while pulling data low
  input wire logic [63:0] switch_state_o,  // applied switches
  input wire logic [63:0] pending_state_o, // latched switches
  input wire logic        hs_mode_o        // high-speed mode seen
);
  // ***************************************************************
  // properties, all on the block clock
  // ***************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_por_clears: assert property (disable iff (1'b0)
    rst_i |=> switch_state_o == '0 && pending_state_o == '0 && sda_oe_n_o)
    else $error("power-on reset left state behind");
  a_pin_clears: assert property (!reset_n_i [*8] |->
    switch_state_o == '0 && pending_state_o == '0)
    else $error("reset pin did not open all switches");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data output value is not low");
  a_apply_whole: assert property ($changed(switch_state_o) |->
    switch_state_o == pending_state_o)
    else $error("applied state differs from latched state");
  a_one_switch: assert property ($changed(pending_state_o) && pending_state_o != '0 |->
    $countones(pending_state_o ^ $past(pending_state_o)) == 1)
    else $error("a write touched more than one switch");
  // a reset pin clear may land while the clock is high, so it is excluded
  a_sda_scl_low: assert property (disable iff (rst_i || !reset_n_i)
    $changed(sda_oe_n_o) |-> !scl_i)
    else $error("data line changed while clock high");
  a_word_scl_low: assert property (disable iff (rst_i || !reset_n_i)
    $changed(pending_state_o) |-> !scl_i)
    else $error("latch changed while clock high");
  a_pull_holds: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*6])
    else $error("data pull released too soon");

  c_ack: cover property ($fell(sda_oe_n_o));
  c_apply: cover property ($changed(switch_state_o) && switch_state_o != '0);
  c_hs: cover property ($rose(hs_mode_o));
endmodule

bind xps_ctrl xps_ctrl_sva chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .switch_state_o(switch_state_o), .pending_state_o(pending_state_o), .hs_mode_o(hs_mode_o));
`default_nettype wire

/* File: tb/xps_i2c_master.sv */
// behavioural serial bus master driving the crosspoint switch control block
`timescale 1ns/1ns
`default_nettype none
module xps_i2c_master (
  input  wire logic sda_i, // resolved data line
  output logic      scl_o, // serial clock, only the master drives it
  output logic      sda_o  // 0 pulls low, 1 releases to the pull-up
);
  // 125 ns clock; clock idles high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one bit: data set while clock low, held over the high phase
  task automatic bit_out(input logic b);
    sda_o = b;
    #31 scl_o = 1'b1;
    #62 scl_o = 1'b0;
    #32;
  endtask
  task automatic start();
    sda_o = 1'b1;
    #31 scl_o = 1'b1;
    #62 sda_o = 1'b0;
    #62 scl_o = 1'b0;
    #32;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #31 scl_o = 1'b1;
    #62 sda_o = 1'b1;
    #62;
  endtask
  // eight bits msb first, then release and sample the ack on the ninth
  task automatic wr(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    sda_o = 1'b1;
    #31 scl_o = 1'b1;
    #31 ack = (sda_i === 1'b0);
    #31 scl_o = 1'b0;
    #32;
  endtask
  task automatic rd(input logic nack, output logic [7:0] d);
    sda_o = 1'b1;
    for (int i = 0; i < 8; i++) begin
      #31 scl_o = 1'b1;
      #31 d = {d[6:0], sda_i};
      #31 scl_o = 1'b0;
      #32;
    end
    bit_out(nack);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_crosspoint_switch_i2c_control.sv */
// self-checking bench for the crosspoint switch serial control block
`timescale 1ns/1ns
`default_nettype none
module test_crosspoint_switch_i2c_control;
  import xps_pkg::*;
  logic        core_clk_i = 1'b0; // 125 MHz block clock
  logic        rst_i      = 1'b1; // power-on reset
  logic        reset_n_i  = 1'b1; // reset pin
  logic [2:0]  strap      = 3'h0; // address straps
  logic        scl, m_sda;        // master pins
  wire  logic  sda_w;             // data line with pull-up
  logic        sda_o, sda_oe_n_o, hs_mode_o;
  logic [63:0] sw, pend, m_app, m_pend; // seen and expected stores
  logic [2:0]  m_row;             // expected readback row
  logic [7:0]  b1, b2, d;
  logic        a0, a1, a2;
  int          n_fail = 0, checked = 0, cycles = 0, seed = 71760;

  assign sda_w = m_sda & (sda_oe_n_o !== 1'b0 || sda_o === 1'b1);
  always #4 core_clk_i = ~core_clk_i;
  xps_i2c_master m_u (.sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
  xps_ctrl dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .addr_strap_bit0_i(strap[0]),
    .addr_strap_bit1_i(strap[1]), .addr_strap_bit2_i(strap[2]), .switch_state_o(sw),
    .pending_state_o(pend), .hs_mode_o(hs_mode_o));

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // row code to {valid, index}, reserved codes give zero
  function automatic logic [3:0] row_of(input logic [3:0] c);
    if (c <= 4'h5) return {1'b1, c[2:0]};
    if (c == 4'h8 || c == 4'h9) return {1'b1, 2'b11, c[0]};
    return 4'h0;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // one word written, then the readback row compared
  task automatic word(input logic [7:0] x, input logic [7:0] y);
    logic [3:0] r;
    r = row_of(x[6:3]);
    m_u.start();
    m_u.wr({ADDR_FIXED, strap, 1'b0}, a0);
    m_u.wr(x, a1);
    m_u.wr(y, a2);
    m_u.stop();
    if (r[3]) begin
      m_pend[{r[2:0], x[2:0]}] = x[7];
      m_row = r[2:0];
      if (y[0]) m_app = m_pend;
    end
    chk("write ack", {a0, a1, a2}, 3'h7);
    chk("applied", sw, m_app);
    chk("pending", pend, m_pend);
    m_u.start();
    m_u.wr({ADDR_FIXED, strap, 1'b1}, a0);
    m_u.rd(1'b0, d);
    chk("readback", {a0, d}, {1'b1, m_app[m_row*8 +: 8]});
    m_u.rd(1'b1, d);
    m_u.stop();
    chk("readback again", d, m_app[m_row*8 +: 8]);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    m_app = '0;
    m_pend = '0;
    m_row = 3'h0;
    tick(5);
    rst_i = 1'b0;
    tick(6);
    chk("reset store", sw | pend, '0);
    chk("reset pins", {hs_mode_o, sda_oe_n_o}, 2'h1);
    for (int s = 0; s < 8; s++) begin
      strap = s[2:0];
      tick(6);
      m_u.start();
      m_u.wr({ADDR_FIXED, strap, 1'b0}, a0);
      m_u.stop();
      m_u.start();
      m_u.wr({ADDR_FIXED, ~strap, 1'b0}, a1);
      m_u.stop();
      chk("address ack", {a0, a1}, 2'h2);
    end
    $display("address test done");
    for (int c = 0; c < 16; c++) word({1'b1, c[3:0], c[2:0]}, 8'h01);
    $display("decode test done");
    for (int i = 0; i < 32; i++) begin
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      word(b1, b2);
    end
    for (int k = 0; k < 4; k++) word({1'b1, 4'h9, k[2:0]}, {7'h55, k == 3});
    $display("write test done");
    m_u.start();
    m_u.wr(8'h0a, a0);
    chk("hs code", {a0, hs_mode_o}, 2'h1);
    m_u.start();
    m_u.wr({ADDR_FIXED, strap, 1'b0}, a1);
    m_u.start();
    m_u.wr({ADDR_FIXED, strap, 1'b1}, a2);
    m_u.stop();
    tick(8);
    chk("hs acks", {a1, a2, hs_mode_o}, 3'h4);
    $display("speed test done");
    reset_n_i = 1'b0;
    tick(10);
    chk("pin reset", sw | pend, '0);
    reset_n_i = 1'b1;
    m_app = '0;
    m_pend = '0;
    m_row = 3'h0;
    tick(8);
    word({1'b1, 4'h2, 3'h5}, 8'h01);
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    tick(6);
    chk("second reset", sw | pend, '0);
    $display("reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
